// *** cpso_fpga_model.sv ***
// FPGA side of the configuration port: makes config_clock and captures data.
// Assumes start is held high by the bench until done rises.
`timescale 1ns/1ns
module cpso_fpga_model (
  input wire logic start,
  input wire logic [15:0] n_edges,
  input wire logic byte_mode,
  input wire logic serial_out_bit,
  input wire logic serial_out_oe,
  input wire logic [7:0] parallel_out_byte,
  input wire logic parallel_out_oe,
  output logic config_clock,
  output logic done
);
  logic [7:0] cap_q[$];
  initial begin
    config_clock = 1'b0;
    done = 1'b0;
    forever begin
      wait (start === 1'b1);
      done = 1'b0;
      #13;
      // Clock stands still outside a frame
      for (int k = 0; k < n_edges; k++) begin
        #32;
        // Taken just before the edge: the value launched by the previous edge
        if (byte_mode && parallel_out_oe) cap_q.push_back(parallel_out_byte);
        else if (!byte_mode && serial_out_oe) cap_q.push_back({7'h00, serial_out_bit});
        config_clock = 1'b1;
        #32 config_clock = 1'b0;
      end
      done = 1'b1;
      wait (start === 1'b0);
    end
  end
endmodule : cpso_fpga_model

// *** cpso_mem.sv ***
// Image store: one byte per address, registered read data.
// Assumes a single clock; contents come from the write port.
`timescale 1ns/1ns
module cpso_mem #(
  parameter int AW = 10
) (
  input wire logic clock,
  input wire logic clock_en,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem_reg [0:(1<<AW)-1];
  initial begin
    if (AW < 2 || AW > 24) $error("cpso_mem: AW out of range");
  end
  always_ff @(posedge clock) begin
    if (clock_en) begin
      if (wr_en) mem_reg[wr_addr] <= wr_data;
      rd_data <= mem_reg[rd_addr];
    end
  end
endmodule : cpso_mem

// *** cpso_pkg.sv ***
// Types for the configuration memory stream-out block.
// Assumes cpso_regs.svh is reachable by bare name.
`include "cpso_regs.svh"
package cpso_pkg;
  typedef enum logic [1:0] {
    CPSO_MSER = 2'b00,
    CPSO_SSER = 2'b01,
    CPSO_MBYTE = 2'b10,
    CPSO_SBYTE = 2'b11
  } cpso_mode_t;
  typedef enum logic [1:0] {
    CPSO_IDLE = 2'b00,
    CPSO_RUN = 2'b01,
    CPSO_DONE = 2'b10
  } cpso_state_t;
  typedef struct packed {
    logic chip_enable_n;
    logic output_enable;
    logic reconfig_pulse_n;
    logic busy;
  } cpso_gate_t;
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } cpso_word_t;
endpackage : cpso_pkg

// *** cpso_regs.svh ***
// Constants for the configuration memory stream-out block.
// Assumes inclusion by cpso_pkg and the design modules only.
`ifndef CPSO_REGS_SVH
`define CPSO_REGS_SVH
`define CPSO_CLK_HZ 50000000
`define CPSO_MAX_CFG_HZ 33000000
`define CPSO_MODE_MSER 2'h0
`define CPSO_MODE_SSER 2'h1
`define CPSO_MODE_MBYTE 2'h2
`define CPSO_MODE_SBYTE 2'h3
`define CPSO_GEN_DIV_HALF 4'h1
`define CPSO_REV_BITS 2
`define CPSO_ESC_BYTE 8'hA5
`endif

// *** cpso_stream_out.sv ***
// Configuration memory stream-out: fetch, decompress, buffer, shift out.
// Assumes config_clock is a separate domain; pins pass through synchronisers.
`timescale 1ns/1ns
`include "cpso_regs.svh"
module cpso_stream_out #(
  parameter int AW = 10,
  parameter int REV_BITS = `CPSO_REV_BITS,
  parameter bit PARALLEL_VARIANT = 1'b1
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_en,
  input wire logic config_clock,
  input wire cpso_pkg::cpso_mode_t mode,
  input wire cpso_pkg::cpso_gate_t gate_pins,
  input wire logic [REV_BITS-1:0] rev_pins,
  input wire logic [REV_BITS-1:0] rev_ctrl,
  input wire logic rev_use_ctrl,
  input wire logic compress_en,
  input wire logic jtag_config_start,
  input wire logic load_en,
  input wire logic [AW-1:0] load_addr,
  input wire logic [7:0] load_data,
  input wire logic [AW-REV_BITS-1:0] image_len,
  input wire logic cascade_in_n,
  output logic cascade_out_n,
  output logic serial_out_bit,
  output logic serial_out_oe,
  output logic [7:0] parallel_out_byte,
  output logic parallel_out_oe,
  output logic gen_clock_out,
  output logic gen_clock_oe,
  output logic reconfig_pulse_n_out,
  output logic reconfig_pulse_n_oe
);
  import cpso_pkg::*;
  localparam int SW = AW - REV_BITS;
  initial begin
    if (REV_BITS < 1 || SW < 2) $error("cpso_stream_out: bad widths");
    if (`CPSO_CLK_HZ / 2 > `CPSO_MAX_CFG_HZ) $error("cpso_stream_out: own clock too fast");
  end

  // Synchronise gate pins and requests into the system domain
  cpso_gate_t gate_s1_reg, gate_s2_reg;
  logic [REV_BITS-1:0] revp_s1_reg, revp_s2_reg;
  logic casc_s1_reg, casc_s2_reg, jtag_s1_reg, jtag_s2_reg, jtag_d_reg;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      gate_s1_reg <= '{1'b1, 1'b0, 1'b1, 1'b0};
      gate_s2_reg <= '{1'b1, 1'b0, 1'b1, 1'b0};
      revp_s1_reg <= '0;
      revp_s2_reg <= '0;
      {casc_s1_reg, casc_s2_reg} <= 2'h3;
      {jtag_s1_reg, jtag_s2_reg, jtag_d_reg} <= 3'h0;
    end else if (clock_en) begin
      gate_s1_reg <= gate_pins;
      gate_s2_reg <= gate_s1_reg;
      revp_s1_reg <= rev_pins;
      revp_s2_reg <= revp_s1_reg;
      casc_s1_reg <= cascade_in_n;
      casc_s2_reg <= casc_s1_reg;
      jtag_s1_reg <= jtag_config_start;
      jtag_s2_reg <= jtag_s1_reg;
      jtag_d_reg <= jtag_s2_reg;
    end
  end

  wire byte_mode = PARALLEL_VARIANT && mode[1];
  wire use_compress = PARALLEL_VARIANT && compress_en;
  wire [REV_BITS-1:0] rev_sel = (PARALLEL_VARIANT && rev_use_ctrl) ? rev_ctrl : revp_s2_reg;
  // Own turn in a cascade starts once the upstream part has finished
  wire our_turn = ~casc_s2_reg;
  wire gates_on = ~gate_s2_reg.chip_enable_n && gate_s2_reg.output_enable &&
    gate_s2_reg.reconfig_pulse_n && our_turn;
  wire busy_ok = ~(byte_mode && gate_s2_reg.busy);
  wire jtag_rise = jtag_s2_reg & ~jtag_d_reg;

  // Fetch and decompress: escape byte, count, value expands to a run
  cpso_state_t state_reg, state_next;
  logic [SW-1:0] rd_ptr_reg;
  logic [1:0] fetch_reg;
  logic [1:0] esc_reg;
  logic [7:0] run_cnt_reg, run_val_reg;
  logic [7:0] mem_q;
  logic push_valid, push_ready;
  cpso_word_t push_word;
  wire last_addr = (rd_ptr_reg == image_len);
  cpso_mem #(.AW(AW)) u_mem (
    .clock(clock),
    .clock_en(clock_en),
    .wr_en(load_en),
    .wr_addr(load_addr),
    .wr_data(load_data),
    .rd_addr({rev_sel, rd_ptr_reg}),
    .rd_data(mem_q)
  );
  wire have_byte = (fetch_reg == 2'h2);
  wire in_run = (run_cnt_reg != 8'h00);
  wire raw_byte = have_byte && !(use_compress && esc_reg == 2'h0 && mem_q == `CPSO_ESC_BYTE)
    && esc_reg == 2'h0;
  assign push_valid = (state_reg == CPSO_RUN) && (in_run || raw_byte);
  assign push_word = '{data: (in_run ? run_val_reg : mem_q),
    last: (in_run ? (run_cnt_reg == 8'h01 && fetch_reg == 2'h3) : last_addr)};
  wire consume = have_byte && (!raw_byte || push_ready) && !in_run;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      CPSO_IDLE: if (gates_on || jtag_rise) state_next = CPSO_RUN;
      CPSO_RUN: if (!gate_s2_reg.reconfig_pulse_n) state_next = CPSO_IDLE;
        else if (push_valid && push_ready && push_word.last) state_next = CPSO_DONE;
      CPSO_DONE: if (!gate_s2_reg.reconfig_pulse_n) state_next = CPSO_IDLE;
      default: state_next = CPSO_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_reg <= CPSO_IDLE;
      rd_ptr_reg <= '0;
      fetch_reg <= 2'h0;
      esc_reg <= 2'h0;
      run_cnt_reg <= 8'h00;
      run_val_reg <= 8'h00;
    end else if (clock_en) begin
      state_reg <= state_next;
      if (state_reg != CPSO_RUN) begin
        rd_ptr_reg <= '0;
        fetch_reg <= 2'h0;
        esc_reg <= 2'h0;
        run_cnt_reg <= 8'h00;
      end else begin
        if (fetch_reg == 2'h0) fetch_reg <= 2'h1;
        else if (fetch_reg == 2'h1) fetch_reg <= 2'h2;
        else if (consume) begin
          if (use_compress && esc_reg == 2'h0 && mem_q == `CPSO_ESC_BYTE) esc_reg <= 2'h1;
          else if (esc_reg == 2'h1) begin
            // Count parks in run_val_reg so no run starts before its value
            run_val_reg <= mem_q;
            esc_reg <= 2'h2;
          end else if (esc_reg == 2'h2) begin
            run_cnt_reg <= run_val_reg;
            run_val_reg <= mem_q;
            esc_reg <= 2'h0;
          end
          if (last_addr) fetch_reg <= 2'h3;
          else begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
            fetch_reg <= 2'h1;
          end
        end
        if (in_run && push_ready) run_cnt_reg <= run_cnt_reg - 8'h01;
      end
    end
  end

  // Two-entry buffer in the data path
  cpso_word_t buf_reg [0:1];
  logic [1:0] cnt_reg;
  logic wp_reg, rp_reg;
  assign push_ready = (cnt_reg != 2'h2);
  wire buf_valid = (cnt_reg != 2'h0);
  logic pop;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt_reg <= 2'h0;
      wp_reg <= 1'b0;
      rp_reg <= 1'b0;
      buf_reg[0] <= '0;
      buf_reg[1] <= '0;
    end else if (clock_en) begin
      if (state_reg == CPSO_IDLE) begin
        cnt_reg <= 2'h0;
        wp_reg <= 1'b0;
        rp_reg <= 1'b0;
      end else begin
        if (push_valid && push_ready) begin
          buf_reg[wp_reg] <= push_word;
          wp_reg <= ~wp_reg;
        end
        if (pop) rp_reg <= ~rp_reg;
        cnt_reg <= cnt_reg + {1'b0, push_valid && push_ready} - {1'b0, pop};
      end
    end
  end

  // Handshake into the link domain: req toggles carry one byte
  logic req_reg, ack_s1_reg, ack_s2_reg, ack_d_reg, pend_reg;
  logic lk_ack_reg;
  cpso_word_t xfer_reg;
  assign pop = buf_valid && !pend_reg;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      req_reg <= 1'b0;
      pend_reg <= 1'b0;
      xfer_reg <= '0;
      {ack_s1_reg, ack_s2_reg, ack_d_reg} <= 3'h0;
    end else if (clock_en) begin
      ack_s1_reg <= lk_ack_reg;
      ack_s2_reg <= ack_s1_reg;
      ack_d_reg <= ack_s2_reg;
      if (pop) begin
        xfer_reg <= buf_reg[rp_reg];
        req_reg <= ~req_reg;
        pend_reg <= 1'b1;
      end else if (ack_s2_reg != ack_d_reg) pend_reg <= 1'b0;
    end
  end

  // Link domain: levels into config_clock, shifting on rising edges
  logic lk_req_s1_reg, lk_req_s2_reg, lk_full_reg;
  logic lk_en_s1_reg, lk_en_s2_reg, lk_bm_s1_reg, lk_bm_s2_reg;
  logic [7:0] lk_shift_reg, lk_hold_reg;
  logic [2:0] lk_bit_reg;
  logic lk_have_reg, lk_last_reg;
  // Done still drains the bytes already buffered or in flight
  wire lk_en_lvl = gates_on && busy_ok && (state_reg != CPSO_IDLE);
  wire lk_new = (lk_req_s2_reg != lk_ack_reg);
  wire lk_need = !lk_have_reg || (lk_bm_s2_reg || lk_bit_reg == 3'h7);
  // Without a next byte the last bit or byte simply stands
  wire lk_adv = lk_en_s2_reg && lk_have_reg && !lk_bm_s2_reg && lk_bit_reg != 3'h7;
  always_ff @(posedge config_clock or posedge reset) begin
    if (reset) begin
      {lk_req_s1_reg, lk_req_s2_reg, lk_en_s1_reg, lk_en_s2_reg} <= 4'h0;
      {lk_bm_s1_reg, lk_bm_s2_reg} <= 2'h0;
      lk_ack_reg <= 1'b0;
      lk_full_reg <= 1'b0;
      lk_hold_reg <= 8'h00;
      lk_shift_reg <= 8'h00;
      lk_bit_reg <= 3'h0;
      lk_have_reg <= 1'b0;
      lk_last_reg <= 1'b0;
    end else begin
      lk_req_s1_reg <= req_reg;
      lk_req_s2_reg <= lk_req_s1_reg;
      lk_en_s1_reg <= lk_en_lvl;
      lk_en_s2_reg <= lk_en_s1_reg;
      lk_bm_s1_reg <= byte_mode;
      lk_bm_s2_reg <= lk_bm_s1_reg;
      if (lk_new && !lk_full_reg) begin
        lk_hold_reg <= xfer_reg.data;
        lk_last_reg <= xfer_reg.last;
        lk_full_reg <= 1'b1;
        lk_ack_reg <= lk_req_s2_reg;
      end
      if (!lk_en_s2_reg) begin
        lk_bit_reg <= 3'h0;
      end else if (lk_need && (lk_full_reg || !lk_have_reg)) begin
        // Next byte taken on this edge; serial starts from its top bit
        if (lk_full_reg) begin
          lk_shift_reg <= lk_hold_reg;
          lk_have_reg <= 1'b1;
          lk_full_reg <= (lk_new && !lk_full_reg);
          lk_bit_reg <= 3'h0;
        end
      end else if (lk_adv) begin
        lk_shift_reg <= {lk_shift_reg[6:0], 1'b0};
        lk_bit_reg <= lk_bit_reg + 3'h1;
      end
    end
  end

  // Outputs launched on rising config_clock; FPGA samples the next edge
  always_ff @(posedge config_clock or posedge reset) begin
    if (reset) begin
      serial_out_bit <= 1'b0;
      parallel_out_byte <= 8'h00;
    end else begin
      serial_out_bit <= lk_shift_reg[7];
      parallel_out_byte <= lk_shift_reg;
    end
  end
  // Also gated on the system side: the link clock may stop with its enable still up
  assign serial_out_oe = lk_en_s2_reg && lk_en_lvl && !byte_mode;
  assign parallel_out_oe = lk_en_s2_reg && lk_en_lvl && byte_mode;

  // Own clock for slave modes of the parallel variant only: half the system rate, below 33 MHz
  logic gen_reg;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) gen_reg <= 1'b0;
    else if (clock_en) gen_reg <= ~gen_reg;
  end
  wire slave_mode = (mode == CPSO_SSER) || (mode == CPSO_SBYTE && PARALLEL_VARIANT);
  assign gen_clock_out = gen_reg;
  assign gen_clock_oe = PARALLEL_VARIANT && slave_mode && (state_reg == CPSO_RUN);

  // Pull the reconfig line low for one cycle on a boundary-scan start
  assign reconfig_pulse_n_out = 1'b0;
  assign reconfig_pulse_n_oe = jtag_rise;
  assign cascade_out_n = (state_reg != CPSO_DONE);
endmodule : cpso_stream_out

// *** cpso_stream_out_chk.sv ***
// Port checker for cpso_stream_out, bound to every instance.
// Assumes the bench holds cascade_in_n low throughout.
`timescale 1ns/1ns
module cpso_stream_out_chk (
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_en,
  input wire logic config_clock,
  input wire cpso_pkg::cpso_mode_t mode,
  input wire cpso_pkg::cpso_gate_t gate_pins,
  input wire logic cascade_in_n,
  input wire logic cascade_out_n,
  input wire logic serial_out_bit,
  input wire logic serial_out_oe,
  input wire logic [7:0] parallel_out_byte,
  input wire logic parallel_out_oe,
  input wire logic gen_clock_out,
  input wire logic gen_clock_oe,
  input wire logic reconfig_pulse_n_out,
  input wire logic reconfig_pulse_n_oe
);
  import cpso_pkg::*;
  property p_ser_oe;
    @(posedge clock) disable iff (reset) serial_out_oe |-> !mode[1];
  endproperty
  a_ser_oe: assert property (p_ser_oe) else $error("serial out on in byte mode");
  property p_par_oe;
    @(posedge clock) disable iff (reset) parallel_out_oe |-> mode[1];
  endproperty
  a_par_oe: assert property (p_par_oe) else $error("byte out on in serial mode");
  property p_par_busy;
    @(posedge config_clock) disable iff (reset)
      (mode[1] && gate_pins.busy)[*8] |-> $stable(parallel_out_byte);
  endproperty
  a_par_busy: assert property (p_par_busy) else $error("byte moved while busy");
  property p_idle_hold;
    @(posedge config_clock) disable iff (reset)
      gate_pins.chip_enable_n[*5] |-> $stable(serial_out_bit);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("bit moved while off");
  property p_gen_toggle;
    @(posedge clock) disable iff (reset) gen_clock_oe && $past(gen_clock_oe) && clock_en
      && $past(clock_en) |-> gen_clock_out != $past(gen_clock_out);
  endproperty
  a_gen_toggle: assert property (p_gen_toggle) else $error("own clock not half rate");
  property p_pulse_one;
    @(posedge clock) disable iff (reset) $rose(reconfig_pulse_n_oe) && clock_en |=> !reconfig_pulse_n_oe;
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("pulse longer than one cycle");
  property p_pulse_low;
    @(posedge clock) disable iff (reset) reconfig_pulse_n_oe |-> !reconfig_pulse_n_out;
  endproperty
  a_pulse_low: assert property (p_pulse_low) else $error("pulse driven high");
  property p_casc;
    @(posedge clock) disable iff (reset) $fell(cascade_out_n) |-> $past(!cascade_in_n, 1);
  endproperty
  a_casc: assert property (p_casc) else $error("done without our turn");
  c_ser: cover property (@(posedge clock) disable iff (reset) serial_out_oe);
  c_par: cover property (@(posedge clock) disable iff (reset) parallel_out_oe);
  c_done: cover property (@(posedge clock) disable iff (reset) $fell(cascade_out_n));
endmodule : cpso_stream_out_chk
bind cpso_stream_out cpso_stream_out_chk u_chk (.clock(clock), .reset(reset),
  .clock_en(clock_en), .config_clock(config_clock), .mode(mode), .gate_pins(gate_pins),
  .cascade_in_n(cascade_in_n), .cascade_out_n(cascade_out_n), .serial_out_bit(serial_out_bit),
  .serial_out_oe(serial_out_oe), .parallel_out_byte(parallel_out_byte),
  .parallel_out_oe(parallel_out_oe), .gen_clock_out(gen_clock_out), .gen_clock_oe(gen_clock_oe),
  .reconfig_pulse_n_out(reconfig_pulse_n_out), .reconfig_pulse_n_oe(reconfig_pulse_n_oe));

// *** testbench.sv ***
// Self-checking bench for cpso_stream_out, one run per mode and revision.
// Assumes the package, checker and FPGA model are compiled first.
`timescale 1ns/1ns
module testbench;
  import cpso_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b0;
  logic start = 1'b0, load_en = 1'b0, jtag = 1'b0, use_ctrl = 1'b0, comp = 1'b0;
  logic cfg_clk, m_done, so_bit, so_oe, po_oe, casc_n, rp_out, rp_oe;
  logic [15:0] n_edges = 16'h0000;
  logic [9:0] load_addr = 10'h000;
  logic [7:0] load_data = 8'h00;
  logic [7:0] po_byte;
  logic [1:0] rev = 2'h0;
  cpso_mode_t mode = CPSO_MSER;
  cpso_gate_t gates = '{1'b1, 1'b0, 1'b1, 1'b0};
  logic [7:0] img[$], exp_q[$];
  int err_count = 0, compares = 0, k;
  always #10 clock = ~clock;
  // Open-drain reconfig wire: pulled up, low when either party pulls
  cpso_stream_out #(.PARALLEL_VARIANT(1'b1)) dut (
    .clock(clock), .reset(reset), .clock_en(1'b1), .config_clock(cfg_clk),
    .mode(mode), .gate_pins({gates.chip_enable_n, gates.output_enable,
    gates.reconfig_pulse_n & ~(rp_oe & ~rp_out), gates.busy}),
    .rev_pins(use_ctrl ? ~rev : rev), .rev_ctrl(use_ctrl ? rev : ~rev), .rev_use_ctrl(use_ctrl),
    .compress_en(comp), .jtag_config_start(jtag), .load_en(load_en), .load_addr(load_addr),
    .load_data(load_data), .image_len(8'h07), .cascade_in_n(1'b0), .cascade_out_n(casc_n),
    .serial_out_bit(so_bit), .serial_out_oe(so_oe), .parallel_out_byte(po_byte),
    .parallel_out_oe(po_oe), .gen_clock_out(), .gen_clock_oe(), .reconfig_pulse_n_out(rp_out),
    .reconfig_pulse_n_oe(rp_oe));
  cpso_fpga_model fm (.start(start), .n_edges(n_edges), .byte_mode(mode[1]),
    .serial_out_bit(so_bit), .serial_out_oe(so_oe), .parallel_out_byte(po_byte),
    .parallel_out_oe(po_oe), .config_clock(cfg_clk), .done(m_done));
  task automatic test_done();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  task automatic check(input bit ok, input string s);
    compares++;
    if (!ok) begin
      err_count++;
      $display("[ERR] %0t %s", $time, s);
    end
  endtask : check
  // Waits for model done (w=1) or cascade low (w=0), bounded
  task automatic wait_on(input bit w);
    for (k = 0; k < 3000 && (w ? m_done : !casc_n) !== 1'b1; k++) @(negedge clock);
    if ((w ? m_done : !casc_n) !== 1'b1) begin
      check(1'b0, "wait ran out");
      test_done();
    end
  endtask : wait_on
  // Escape byte, count, value expands to count copies
  function automatic void expand(input bit as_bits);
    logic [7:0] q[$];
    for (int j = 0; j < img.size(); j++)
      if (comp && img[j] == 8'hA5) begin
        repeat (img[j+1]) q.push_back(img[j+2]);
        j += 2;
      end else q.push_back(img[j]);
    exp_q = {};
    foreach (q[x]) for (int b = 7; b >= 0; b--) if (as_bits) exp_q.push_back({7'h00, q[x][b]});
    if (!as_bits) exp_q = q;
  endfunction : expand
  // Pacing is approximate, so the expected stream is matched in order
  function automatic bit sub_ok();
    int j = 0;
    foreach (fm.cap_q[i]) if (j < exp_q.size() && fm.cap_q[i] === exp_q[j]) j++;
    return j == exp_q.size();
  endfunction : sub_ok
  task automatic run(input int m);
    logic [7:0] b;
    img = {};
    for (int j = 0; j < 8; j++) begin
      b = 8'($urandom);
      img.push_back((m == 2 && b == 8'hA5) ? 8'h5A : b);
    end
    if (m == 0) img[0] = 8'hA5;
    if (m == 2) img[1] = 8'hA5;
    if (m == 2) img[2] = 8'($urandom_range(4, 2));
    for (int j = 0; j < 8; j++) begin
      @(negedge clock);
      load_en = 1'b1;
      load_addr = {m[1:0], 8'(j)};
      load_data = img[j];
    end
    @(negedge clock) load_en = 1'b0;
    mode = cpso_mode_t'(m);
    rev = m[1:0];
    use_ctrl = m[0];
    comp = (m == 2);
    expand(m < 2);
    fm.cap_q = {};
    n_edges = (m < 2) ? 16'h008C : 16'h0078;
    start = 1'b1;
    repeat (24) @(negedge clock);
    gates.chip_enable_n = 1'b0;
    gates.output_enable = 1'b1;
    jtag = 1'b1;
    @(negedge clock) jtag = 1'b0;
    for (k = 0; k < 1000 && m_done !== 1'b1; k++) begin
      if (k % 16 == 0) gates.busy = mode[1] & 1'($urandom);
      @(negedge clock);
    end
    gates.busy = 1'b0;
    wait_on(1'b1);
    start = 1'b0;
    wait_on(1'b0);
    check(sub_ok(), "stream mismatch");
    gates.reconfig_pulse_n = 1'b0;
    repeat (8) @(negedge clock);
    check(casc_n === 1'b1, "no rewind on reconfig");
    gates = '{1'b1, 1'b0, 1'b1, 1'b0};
    repeat (8) @(negedge clock);
  endtask : run
  initial begin
    k = $urandom(32'h3D51015F);
    // A real rising edge, since the link clock is still during reset
    #1 reset = 1'b1;
    repeat (6) @(posedge clock);
    @(negedge clock) reset = 1'b0;
    repeat (3) @(negedge clock);
    for (int m = 0; m < 4; m++) run(m);
    test_done();
  end
endmodule : testbench
